// *** bench/dtf_ctrl_assertions.sv ***
// port-level checker of the shutdown, sweep and bus timing
`timescale 1ns/1ps
module dtf_ctrl_assertions (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic over_temp,
	input wire logic load_dac_strobe_n,
	input wire logic amp_power_down,
	input wire logic upd_valid,
	input wire logic [5:0] upd_channel
);
	// data phase flags rebuilt from the bus, so releases can be tied to a write
	logic wr_dph_q;
	logic rd_dph_q;
	always_ff @(posedge ref_clk) begin
		wr_dph_q <= !rst && hsel && hready && htrans[1] && hwrite;
		rd_dph_q <= !rst && hsel && hready && htrans[1] && !hwrite;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_trip_cause: assert property ($rose(amp_power_down) |-> $past(over_temp))
		else $error("shutdown without over-temperature");
	// a control-register clear releases one cycle after its data phase, so skip that cycle too
	a_shut_hold: assert property (amp_power_down && !wr_dph_q && !$past(wr_dph_q) |=> amp_power_down)
		else $error("shutdown left without a register write");
	a_rdata_idle: assert property (!rd_dph_q |-> hrdata == 32'h0000_0000)
		else $error("read data outside a read data phase");
	a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus response not okay and ready");
	a_sweep_first: assert property ($fell(load_dac_strobe_n) |-> ##2 upd_valid && upd_channel == 6'h00)
		else $error("sweep did not start at channel zero");
	a_sweep_last: assert property ($fell(load_dac_strobe_n) |-> ##41 upd_valid && upd_channel == 6'h27)
		else $error("sweep did not reach the last channel");
	a_sweep_step: assert property (upd_valid && $past(upd_valid) |-> upd_channel == $past(upd_channel) + 6'h01)
		else $error("sweep channels out of order");
	a_upd_range: assert property (upd_valid |-> upd_channel < 6'h28)
		else $error("update of a channel that does not exist");
endmodule
bind dtf_ctrl dtf_ctrl_assertions chk_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .over_temp(over_temp), .load_dac_strobe_n(load_dac_strobe_n),
	.amp_power_down(amp_power_down), .upd_valid(upd_valid), .upd_channel(upd_channel));

// *** bench/dtf_host_model.sv ***
// host model driving parallel channel writes and the load strobe
`timescale 1ns/1ps
module dtf_host_model (
	input wire logic ref_clk,
	input wire logic host_wr_ready,
	output logic host_wr,
	output logic [5:0] host_ch,
	output logic host_sel_b,
	output logic [13:0] host_data,
	output logic load_dac_strobe_n
);
	// idle: no write, strobe high, channel parked on an ignored number
	initial begin
		host_wr = 1'b0;
		host_ch = 6'h3f;
		host_sel_b = 1'b0;
		host_data = 14'h0000;
		load_dac_strobe_n = 1'b1;
	end
	// one write per cycle
	// back to back writes, each held until ready is seen high
	task automatic burst(input logic [5:0] ch0, input int n, input logic b,
		input logic [13:0] d0);
		@(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			host_wr <= 1'b1;
			host_ch <= ch0 + 6'(i);
			host_sel_b <= b;
			host_data <= d0 + 14'(i);
			do @(posedge ref_clk); while (host_wr_ready !== 1'b1);
		end
		// released lines show a changed value so stale data cannot pass
		host_wr <= 1'b0;
		host_ch <= 6'h3f;
		host_data <= ~host_data;
	endtask
	// one strobe pulse, then wait out the full sweep of all channels
	task automatic strobe();
		@(posedge ref_clk);
		load_dac_strobe_n <= 1'b0;
		@(posedge ref_clk);
		load_dac_strobe_n <= 1'b1;
		repeat (45) @(posedge ref_clk);
	endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench of the toggle, thermal and write-queue control
`timescale 1ns/1ps
`include "dtf_map.svh"
module tb_top;
	logic ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic par_mode, fifo_enable_pin, host_wr, host_sel_b, host_wr_ready;
	logic load_dac_strobe_n, over_temp, amp_power_down, upd_valid;
	logic [5:0] host_ch, upd_channel;
	logic [13:0] host_data, upd_code;
	logic [13:0] codes [0:63];
	int failures = 0;
	int n_tests = 0;
	int n_upd = 0;
	int cyc = 0;
	// single slave: its ready is the bus ready
	assign hready = hreadyout;
	dtf_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.par_mode(par_mode), .fifo_enable_pin(fifo_enable_pin), .host_wr(host_wr),
		.host_ch(host_ch), .host_sel_b(host_sel_b), .host_data(host_data),
		.host_wr_ready(host_wr_ready), .load_dac_strobe_n(load_dac_strobe_n),
		.over_temp(over_temp), .amp_power_down(amp_power_down), .upd_valid(upd_valid),
		.upd_channel(upd_channel), .upd_code(upd_code));
	dtf_host_model host_u (.ref_clk(ref_clk), .host_wr_ready(host_wr_ready),
		.host_wr(host_wr), .host_ch(host_ch), .host_sel_b(host_sel_b),
		.host_data(host_data), .load_dac_strobe_n(load_dac_strobe_n));
	// 100 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// record every output update; a hang past the ceiling ends the run
	always @(posedge ref_clk) begin
		cyc++;
		if (upd_valid === 1'b1) begin
			codes[upd_channel] <= upd_code;
			n_upd <= n_upd + 1;
		end
		if (cyc == 6000) begin
			failures++;
			end_of_test();
		end
	end
	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single transfer; read data taken at the data phase edge
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_defaults();
		for (int a = 0; a <= 20; a += 4) begin
			if (a != 16) begin
				ahb(1'b0, a, 32'h0);
				chk("reset value", r, 32'h0);
			end
		end
		ahb(1'b0, `DTF_OFF_STATE, 32'h0);
		chk("state parallel", r, 32'h8);
		$display("test defaults done");
	endtask
	task automatic t_toggle();
		n_upd = 0;
		ahb(1'b1, `DTF_OFF_CTRL, 32'h4);
		host_u.burst(6'd0, 1, 1'b0, 14'h0111);
		host_u.burst(6'd0, 1, 1'b1, 14'h0222);
		host_u.burst(6'd8, 1, 1'b1, 14'h0333);
		repeat (3) @(posedge ref_clk);
		chk("direct no update", n_upd, 32'd0);
		host_u.strobe();
		chk("first strobe", codes[0], 14'h0111);
		chk("refused b", codes[8], 14'h0000);
		host_u.strobe();
		chk("second strobe", codes[0], 14'h0222);
		ahb(1'b1, `DTF_OFF_CTRL, 32'h0);
		host_u.strobe();
		chk("after disable", codes[0], 14'h0111);
		ahb(1'b0, `DTF_OFF_STAT, 32'h0);
		chk("refused flag", r, 32'h2);
		$display("test toggle done");
	endtask
	task automatic t_irq();
		chk("irq masked", irq, 1'b0);
		ahb(1'b1, `DTF_OFF_MASK, 32'h2);
		ahb(1'b0, `DTF_OFF_MASK, 32'h0);
		chk("mask", r, 32'h2);
		chk("irq raised", irq, 1'b1);
		ahb(1'b1, `DTF_OFF_STAT, 32'h2);
		ahb(1'b0, `DTF_OFF_STAT, 32'h0);
		chk("status cleared", r, 32'h0);
		chk("irq cleared", irq, 1'b0);
		$display("test irq done");
	endtask
	task automatic t_therm();
		ahb(1'b1, `DTF_OFF_MASK, 32'h1);
		over_temp <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("monitor off", amp_power_down, 1'b0);
		ahb(1'b1, `DTF_OFF_CTRL, 32'h100);
		repeat (3) @(posedge ref_clk);
		chk("shutdown", amp_power_down, 1'b1);
		chk("trip irq", irq, 1'b1);
		ahb(1'b1, `DTF_OFF_CMD, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("power-up hot", amp_power_down, 1'b1);
		over_temp <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("held when cool", amp_power_down, 1'b1);
		ahb(1'b1, `DTF_OFF_CMD, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("power-up cool", amp_power_down, 1'b0);
		over_temp <= 1'b1;
		repeat (3) @(posedge ref_clk);
		ahb(1'b1, `DTF_OFF_CTRL, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("monitor cleared", amp_power_down, 1'b0);
		over_temp <= 1'b0;
		ahb(1'b1, `DTF_OFF_STAT, 32'h1);
		ahb(1'b0, `DTF_OFF_STAT, 32'h0);
		chk("trip cleared", r, 32'h0);
		$display("test thermal done");
	endtask
	task automatic t_fifo();
		fifo_enable_pin <= 1'b1;
		do_reset();
		fifo_enable_pin <= 1'b0;
		ahb(1'b0, `DTF_OFF_STATE, 32'h0);
		chk("queue mode kept", r, 32'hc);
		n_upd = 0;
		host_u.burst(6'd0, 40, 1'b0, 14'h1000);
		repeat (104) @(posedge ref_clk);
		chk("group updated", n_upd, 32'd40);
		chk("last code", codes[39], 14'h1027);
		ahb(1'b0, `DTF_OFF_STAT, 32'h0);
		chk("drained", r, 32'h8);
		$display("test queue done");
	endtask
	task automatic t_serial();
		par_mode <= 1'b0;
		fifo_enable_pin <= 1'b1;
		do_reset();
		ahb(1'b0, `DTF_OFF_STATE, 32'h0);
		chk("serial no queue", r, 32'h0);
		n_upd = 0;
		host_u.burst(6'd5, 1, 1'b0, 14'h0055);
		repeat (8) @(posedge ref_clk);
		chk("serial no drain", n_upd, 32'd0);
		$display("test serial done");
	endtask
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		par_mode = 1'b1;
		fifo_enable_pin = 1'b0;
		over_temp = 1'b0;
		do_reset();
		t_defaults();
		t_toggle();
		t_irq();
		t_therm();
		t_fifo();
		t_serial();
		end_of_test();
	end
endmodule

// *** hw/dtf_ctrl.sv ***
// toggle, thermal and write-queue control of a 40-channel converter
`timescale 1ns/1ps
`include "dtf_map.svh"
// What this block does
// R1: clearing toggle enable leaves toggle mode
// R2: first strobe after disable shows A
// R3: thermal protection only while enable set
// R4: over-temperature powers down all amplifiers
// R5: soft power-up when cool, or disable, restores
// R6: queue offered only in parallel mode
// R7: queue setting captured once after reset
// R8: host changes setting only through reset
// R9: one write per cycle accepted when queued
// R10: full group drains within group update time
// R11: five toggle bits, one per group
// R12: B writes only with group toggle on
// R13: shutdown state held until released
module dtf_ctrl
	import dtf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	input wire logic par_mode,
	input wire logic fifo_enable_pin,
	input wire logic host_wr,
	input wire logic [5:0] host_ch,
	input wire logic host_sel_b,
	input wire logic [13:0] host_data,
	output logic host_wr_ready,
	input wire logic load_dac_strobe_n,
	input wire logic over_temp,
	output logic amp_power_down,
	output logic upd_valid,
	output logic [5:0] upd_channel,
	output logic [13:0] upd_code
);
	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [31:0] ctrl_q; // control register
	logic [`DTF_ST_W-1:0] stat_q; // sticky events
	logic [`DTF_ST_W-1:0] mask_q; // interrupt mask
	logic [`DTF_ST_W-1:0] stat_set; // events this cycle
	logic [7:0] addr_q; // data-phase address
	logic wr_pend_q; // write data phase pending
	logic rd_pend_q; // read data phase pending
	logic soft_pwrup; // one-cycle power-up command
	logic init_done_q; // straps captured
	logic fifo_mode_q; // queue in use until next reset
	logic par_mode_q; // interface mode captured at init
	logic [4:0] tog; // toggle enable per group
	logic [4:0] show_b_q; // group currently shows B
	logic [4:0] next_b_q; // next strobe shows B
	logic load_dac_strobe_prev_q; // strobe level last cycle
	logic load_dac_strobe_fall; // strobe asserted
	logic sweep_q; // output sweep running
	logic [5:0] idx_q; // sweep channel
	logic [13:0] a_mem [0:39]; // A data registers
	logic [13:0] b_mem [0:39]; // B data registers
	logic acc; // host write accepted
	logic q_in_ready;
	logic q_out_valid;
	logic q_pop;
	logic [20:0] q_out;
	logic [5:0] q_level;
	logic [7:0] pace_q; // cycles until next drain
	logic ap_valid; // apply a write to A or B
	logic [5:0] ap_ch;
	logic ap_b;
	logic [13:0] ap_data;
	logic shut;
	logic trip;
	logic wr_ctrl;
	logic wr_cmd;
	logic wr_stat;
	logic wr_mask;

	// ****************************************************************
	// bus slave
	// ****************************************************************
	// zero wait states, always an okay response
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// address phase capture; hsize is not checked, every access is a word
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite;
			rd_pend_q <= hsel && htrans[1] && !hwrite;
			addr_q <= haddr[7:0];
		end
	end

	assign wr_ctrl = wr_pend_q && (addr_q == `DTF_OFF_CTRL);
	assign wr_cmd = wr_pend_q && (addr_q == `DTF_OFF_CMD);
	assign wr_stat = wr_pend_q && (addr_q == `DTF_OFF_STAT);
	assign wr_mask = wr_pend_q && (addr_q == `DTF_OFF_MASK);
	assign soft_pwrup = wr_cmd && hwdata[`DTF_CMD_PWRUP];

	// read mux in the data phase; unmapped offsets read zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_pend_q) begin
			unique case (addr_q)
				`DTF_OFF_CTRL: hrdata = ctrl_q;
				`DTF_OFF_STAT: hrdata = 32'(stat_q);
				`DTF_OFF_MASK: hrdata = 32'(mask_q);
				`DTF_OFF_STATE: hrdata = {22'h000000, q_level, par_mode_q,
					fifo_mode_q, sweep_q, shut};
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// control register; only toggle and thermal bits are kept
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_q <= `DTF_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= 32'h0000_0000;
			// R11: one enable bit per group
			ctrl_q[`DTF_CTRL_TOG_HI:`DTF_CTRL_TOG_LO] <=
				hwdata[`DTF_CTRL_TOG_HI:`DTF_CTRL_TOG_LO];
			ctrl_q[`DTF_CTRL_THERM] <= hwdata[`DTF_CTRL_THERM];
		end
	end

	assign tog = ctrl_q[`DTF_CTRL_TOG_HI:`DTF_CTRL_TOG_LO];

	// ****************************************************************
	// interrupts
	// ****************************************************************
	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~(wr_stat ? hwdata[`DTF_ST_W-1:0] : '0)) | stat_set;
		end
	end

	// mask register, same layout as status
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mask_q <= '0;
		end else if (wr_mask) begin
			mask_q <= hwdata[`DTF_ST_W-1:0];
		end
	end

	assign irq = |(stat_q & mask_q);

	// event collection
	always_comb begin
		stat_set = '0;
		stat_set[`DTF_ST_THERM] = trip;
		stat_set[`DTF_ST_BREJ] = host_wr && (host_ch < 6'(`DTF_NUM_CH)) && host_sel_b
			&& !tog[host_ch[5:3]];
		stat_set[`DTF_ST_OVF] = host_wr && acc && fifo_mode_q && !q_in_ready;
		stat_set[`DTF_ST_DONE] = q_pop && (q_level == 6'h01) && !(acc && fifo_mode_q);
	end

	// ****************************************************************
	// thermal protection
	// ****************************************************************
	// R3: the enable bit gates the monitor
	dtf_thermal u_thermal (
		.ref_clk(ref_clk),
		.rst(rst),
		.monitor_en(ctrl_q[`DTF_CTRL_THERM]),
		.over_temp(over_temp),
		.soft_pwrup(soft_pwrup),
		.shut(shut),
		.trip(trip)
	);

	// R4: every amplifier follows the shutdown state
	assign amp_power_down = shut;

	// ****************************************************************
	// initialisation straps
	// ****************************************************************
	// captured on the first edge after reset release, then frozen
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			init_done_q <= 1'b0;
			fifo_mode_q <= 1'b0;
			par_mode_q <= 1'b0;
		end else if (!init_done_q) begin
			init_done_q <= 1'b1;
			par_mode_q <= par_mode;
			// R7: sampled once per reset
			// R8: later pin changes wait for reset
			// R6: serial modes never queue
			fifo_mode_q <= fifo_enable_pin && par_mode;
		end
	end

	// ****************************************************************
	// host writes and the queue
	// ****************************************************************
	// R12: a B write needs its group in toggle mode
	assign acc = host_wr && init_done_q && (host_ch < 6'(`DTF_NUM_CH))
		&& (!host_sel_b || tog[host_ch[5:3]]);

	// R9: ready every cycle while the queue has room
	assign host_wr_ready = fifo_mode_q ? q_in_ready : 1'b1;

	dtf_fifo u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(acc && fifo_mode_q),
		.in_ready(q_in_ready),
		.in_data({host_sel_b, host_ch, host_data}),
		.out_valid(q_out_valid),
		.out_ready(!sweep_q && !load_dac_strobe_fall && (pace_q == 8'h00)),
		.out_data(q_out),
		.level(q_level)
	);

	assign q_pop = q_out_valid && !sweep_q && !load_dac_strobe_fall && (pace_q == 8'h00);

	// R10: drain pacing keeps a full group inside the update time
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pace_q <= 8'h00;
		end else if (q_pop) begin
			pace_q <= 8'(`DTF_CH_UPD_CYC - 1);
		end else if (pace_q != 8'h00) begin
			pace_q <= pace_q - 8'h01;
		end
	end

	// write path into A or B: direct, or from the queue head
	always_comb begin
		if (fifo_mode_q) begin
			ap_valid = q_pop;
			ap_b = q_out[20];
			ap_ch = q_out[19:14];
			ap_data = q_out[13:0];
		end else begin
			ap_valid = acc;
			ap_b = host_sel_b;
			ap_ch = host_ch;
			ap_data = host_data;
		end
	end

	// data registers, cleared at reset so no unknown code leaves
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < `DTF_NUM_CH; i++) begin
				a_mem[i] <= 14'h0000;
				b_mem[i] <= 14'h0000;
			end
		end else if (ap_valid) begin
			if (ap_b) begin
				b_mem[ap_ch] <= ap_data;
			end else begin
				a_mem[ap_ch] <= ap_data;
			end
		end
	end

	// ****************************************************************
	// load strobe and toggle selection
	// ****************************************************************
	// strobe edge detect; pin is taken as synchronous
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			load_dac_strobe_prev_q <= 1'b1;
		end else begin
			load_dac_strobe_prev_q <= load_dac_strobe_n;
		end
	end

	assign load_dac_strobe_fall = load_dac_strobe_prev_q && !load_dac_strobe_n;

	// per-group A/B selection, one copy per group
	for (genvar g = 0; g < `DTF_NUM_GRP; g++) begin : g_grp
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				show_b_q[g] <= 1'b0;
				next_b_q[g] <= 1'b0;
			end else if (!tog[g]) begin
				// R1: toggle off, next strobe restarts at A
				next_b_q[g] <= 1'b0;
				// R2: strobe after disable shows A
				if (load_dac_strobe_fall) begin
					show_b_q[g] <= 1'b0;
				end
			end else if (load_dac_strobe_fall) begin
				// strobes alternate, the first one showing A
				show_b_q[g] <= next_b_q[g];
				next_b_q[g] <= !next_b_q[g];
			end
		end
	end

	// output sweep after each strobe; a new strobe restarts it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sweep_q <= 1'b0;
			idx_q <= 6'h00;
		end else if (load_dac_strobe_fall) begin
			sweep_q <= 1'b1;
			idx_q <= 6'h00;
		end else if (sweep_q) begin
			sweep_q <= (idx_q != 6'(`DTF_NUM_CH - 1));
			idx_q <= idx_q + 6'h01;
		end
	end

	// ****************************************************************
	// output updates
	// ****************************************************************
	// sweep has priority; a drained entry shows only if it is selected
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			upd_valid <= 1'b0;
			upd_channel <= 6'h00;
			upd_code <= 14'h0000;
		end else if (sweep_q) begin
			upd_valid <= 1'b1;
			upd_channel <= idx_q;
			upd_code <= show_b_q[idx_q[5:3]] ? b_mem[idx_q] : a_mem[idx_q];
		end else if (q_pop) begin
			upd_valid <= 1'b1;
			upd_channel <= ap_ch;
			if (ap_b == show_b_q[ap_ch[5:3]]) begin
				upd_code <= ap_data;
			end else begin
				upd_code <= show_b_q[ap_ch[5:3]] ? b_mem[ap_ch] : a_mem[ap_ch];
			end
		end else begin
			upd_valid <= 1'b0;
		end
	end
endmodule

// *** hw/dtf_fifo.sv ***
// write queue for the parallel interface, one entry per channel write
`timescale 1ns/1ps
module dtf_fifo
	import dtf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [20:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [20:0] out_data,
	output logic [5:0] level
);
	// ****************************************************************
	// storage and pointers
	// ****************************************************************
	logic [20:0] mem [0:39]; // queued entries
	logic [5:0] wp_q; // write pointer
	logic [5:0] rp_q; // read pointer
	logic [5:0] cnt_q; // entries held
	logic push;
	logic pop;

	assign in_ready = (cnt_q != 6'(`DTF_FIFO_DEPTH));
	assign out_valid = (cnt_q != 6'h00);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rp_q];
	assign level = cnt_q;

	// entry storage; no reset needed, reads are gated by the count
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	// pointers wrap at the last entry
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wp_q <= 6'h00;
			rp_q <= 6'h00;
			cnt_q <= 6'h00;
		end else begin
			if (push) begin
				wp_q <= (wp_q == 6'(`DTF_FIFO_DEPTH - 1)) ? 6'h00 : wp_q + 6'h01;
			end
			if (pop) begin
				rp_q <= (rp_q == 6'(`DTF_FIFO_DEPTH - 1)) ? 6'h00 : rp_q + 6'h01;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 6'h01;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 6'h01;
			end
		end
	end
endmodule

// *** hw/dtf_thermal.sv ***
// over-temperature shutdown state machine
`timescale 1ns/1ps
module dtf_thermal
	import dtf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic monitor_en,
	input wire logic over_temp,
	input wire logic soft_pwrup,
	output logic shut,
	output logic trip
);
	// ****************************************************************
	// state
	// ****************************************************************
	dtf_therm_st_t st_q; // current protection state

	// state transitions; trip is the one-cycle entry event
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= DTF_RUN;
			trip <= 1'b0;
		end else begin
			trip <= 1'b0;
			unique case (st_q)
				DTF_RUN: begin
					// R3: only when enabled
					// R4: trip on over-temperature
					if (monitor_en && over_temp) begin
						st_q <= DTF_SHUT;
						trip <= 1'b1;
					end
				end
				DTF_SHUT: begin
					// R5: cool soft power-up or disable
					// R13: held until released
					if (!monitor_en || (soft_pwrup && !over_temp)) begin
						st_q <= DTF_RUN;
					end
				end
				default: begin
					st_q <= DTF_RUN;
				end
			endcase
		end
	end

	assign shut = (st_q == DTF_SHUT);
endmodule

// *** include/dtf_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef DTF_MAP_SVH
`define DTF_MAP_SVH

// ****************************************************************
// register map (byte offsets, low address byte decoded)
// ****************************************************************
`define DTF_OFF_CTRL 8'h00
`define DTF_OFF_CMD 8'h04
`define DTF_OFF_STAT 8'h08
`define DTF_OFF_MASK 8'h0c
`define DTF_OFF_STATE 8'h10
`define DTF_CTRL_RST 32'h0000_0000

// ****************************************************************
// field positions
// ****************************************************************
`define DTF_CTRL_TOG_LO 2
`define DTF_CTRL_TOG_HI 6
`define DTF_CTRL_THERM 8
`define DTF_CMD_PWRUP 0
`define DTF_ST_THERM 0
`define DTF_ST_BREJ 1
`define DTF_ST_OVF 2
`define DTF_ST_DONE 3
`define DTF_ST_W 4

// ****************************************************************
// geometry and timing
// ****************************************************************
`define DTF_NUM_CH 40
`define DTF_NUM_GRP 5
`define DTF_CODE_W 14
`define DTF_CH_W 6
`define DTF_ENT_W 21
`define DTF_FIFO_DEPTH 40
`define DTF_CLK_NS 100
`define DTF_WR_CYCLE_NS 40
`define DTF_WR_CYCLE_CYC ((`DTF_WR_CYCLE_NS + `DTF_CLK_NS - 1) / `DTF_CLK_NS)
`define DTF_GROUP_UPD_NS 14400
`define DTF_GROUP_UPD_CYC (`DTF_GROUP_UPD_NS / `DTF_CLK_NS)
`define DTF_CH_UPD_CYC (`DTF_GROUP_UPD_CYC / `DTF_NUM_CH)

`endif

// *** include/dtf_pkg.sv ***
// shared types of the toggle, thermal and write-queue control slice
package dtf_pkg;
	// thermal protection states, one-hot
	typedef enum logic [1:0] {
		DTF_RUN = 2'b01,
		DTF_SHUT = 2'b10
	} dtf_therm_st_t;
	// one output code
	typedef logic [13:0] dtf_code_t;
endpackage
